// ---- shared/capture_timer_params.svh ----
// constants of the 8-bit input-capture timer: offsets, fields, resets
`ifndef CAPTURE_TIMER_PARAMS_SVH
`define CAPTURE_TIMER_PARAMS_SVH

// ----------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------
`define CT_MODE_IDX      10'h0BC
`define CT_FALL_IDX      10'h0BD
`define CT_RISE_IDX      10'h0BE
`define CT_COUNT_IDX     10'h0BF
`define CT_IRQ_STAT_IDX  10'h0C0
`define CT_IRQ_EN_IDX    10'h0C1
`define CT_IRQ_CLR_IDX   10'h0C2
`define CT_ADDR_W        12

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define CT_CKS_LSB       0
`define CT_CCLR_LSB      2
`define CT_SEL_W         2
`define CT_EDGE_BIT      4
`define CT_OVERFLOW_IRQ_ENABLE_BIT      5
`define CT_OVERFLOW_FLAG_LOW_BIT      6
`define CT_OVERFLOW_FLAG_HIGH_BIT      7
`define CT_MODE_RESET    8'h00

// ----------------------------------------------------------------
// counter, captures and interrupt bits
// ----------------------------------------------------------------
`define CT_CNT_W         8
`define CT_CNT_MAX       8'hFF
`define CT_CNT_RESET     8'h00
`define CT_CAP_RESET     8'h00
`define CT_IRQ_W         2
`define CT_IRQ_OVF_BIT   0
`define CT_IRQ_CAP_BIT   1
`define CT_IRQ_RESET     2'h0

// ----------------------------------------------------------------
// prescaler: low bits of the divider that make each tick
// ----------------------------------------------------------------
`define CT_PRESCALE_W    6
`define CT_DIV64_BITS    6
`define CT_DIV32_BITS    5
`define CT_DIV2_BITS     1
`define CT_SUB_DIV_W     2

`endif

// ---- shared/capture_timer_pkg.sv ----
// types of the 8-bit input-capture timer
package capture_timer_pkg;

  // increment source of the counter, in field order
  typedef enum logic [1:0] {
    CLK_DIV64,
    CLK_DIV32,
    CLK_DIV2,
    CLK_SUB4
  } clock_src_t;

  // which capture edges clear the counter, in field order
  typedef enum logic [1:0] {
    CLR_NONE,
    CLR_FALL,
    CLR_RISE,
    CLR_BOTH
  } clear_mode_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_RD_WAIT
  } bus_state_t;

endpackage

// ---- shared/tick_if.sv ----
// count tick and its source selection between timer and prescaler
`timescale 1ns/1ps
interface tick_if;
  import capture_timer_pkg::*;

  clock_src_t clk_src;
  logic       tick;

  modport src (input clk_src, output tick);
  modport snk (output clk_src, input tick);
endinterface

// ---- core/capture_prescaler.sv ----
// prescaler making the selected count tick from system clock or subclock
`timescale 1ns/1ps
`include "capture_timer_params.svh"
module capture_prescaler #(
  parameter int DIV_W = `CT_PRESCALE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // subclock pin, asynchronous
  input wire logic subclock_in,
  // tick towards the counter
  tick_if.src      tk
);
  import capture_timer_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DIV_W-1:0]         div_q;
  logic [DIV_W-1:0]         div_d;
  logic [2:0]               sub_q;
  logic [2:0]               sub_d;
  logic [`CT_SUB_DIV_W-1:0] sub_div_q;
  logic [`CT_SUB_DIV_W-1:0] sub_div_d;
  logic                     tick_q;
  logic                     tick_d;
  logic                     sub_rise;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    div_d = div_q + 1'b1;
    // sub_q[0] feeds only sub_q[1]; edges come from the later stages
    sub_d = {sub_q[1:0], subclock_in};
    sub_rise = sub_q[1] & ~sub_q[2];
    sub_div_d = sub_div_q;
    if (sub_rise) begin
      sub_div_d = sub_div_q + 1'b1;
    end
    unique case (tk.clk_src)
      CLK_DIV64: tick_d = &div_q[`CT_DIV64_BITS-1:0];
      CLK_DIV32: tick_d = &div_q[`CT_DIV32_BITS-1:0];
      CLK_DIV2:  tick_d = &div_q[`CT_DIV2_BITS-1:0];
      CLK_SUB4:  tick_d = sub_rise & (&sub_div_q);
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q     <= '0;
      sub_q     <= '0;
      sub_div_q <= '0;
      tick_q    <= 1'b0;
    end else begin
      div_q     <= div_d;
      sub_q     <= sub_d;
      sub_div_q <= sub_div_d;
      tick_q    <= tick_d;
    end
  end

  assign tk.tick = tick_q;
endmodule

// ---- core/capture_timer_8bit.sv ----
// 8-bit input-capture timer with AHB-Lite register slave and interrupt
`timescale 1ns/1ps
`include "capture_timer_params.svh"

// Overview of operation
// - clock select picks system clock /64, /32, /2 or subclock /4
// - clear field: never, falling, rising or both capture edges clear counter
// - capture interrupt on rising edge when select bit clear, falling when set
// - overflow interrupt enable gates the overflow request
// - low overflow flag sets on FF to 00; cleared by read one, write zero
// - high overflow flag sets on FF to 00; cleared by read one, write zero
// - writes to flag bits 7 and 6 only clear; writing one keeps them
// - falling capture edge copies counter into falling capture register
// - rising capture edge copies counter into rising capture register
// - mode register resets to zero; bits 5..0 write-only, flags clear-only
module capture_timer_8bit (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output      logic [31:0] HRDATA,
  output      logic        HREADYOUT,
  output      logic        HRESP,
  // pins
  input  wire logic        CAPTURE_IN,
  input  wire logic        SUBCLOCK_IN,
  // interrupt
  output      logic        IRQ
);
  import capture_timer_pkg::*;

  localparam logic [`CT_ADDR_W-1:0] MODE_ADDR  = {`CT_MODE_IDX, 2'b00};
  localparam logic [`CT_ADDR_W-1:0] FALL_ADDR  = {`CT_FALL_IDX, 2'b00};
  localparam logic [`CT_ADDR_W-1:0] RISE_ADDR  = {`CT_RISE_IDX, 2'b00};
  localparam logic [`CT_ADDR_W-1:0] COUNT_ADDR = {`CT_COUNT_IDX, 2'b00};
  localparam logic [`CT_ADDR_W-1:0] STAT_ADDR  = {`CT_IRQ_STAT_IDX, 2'b00};
  localparam logic [`CT_ADDR_W-1:0] EN_ADDR    = {`CT_IRQ_EN_IDX, 2'b00};
  localparam logic [`CT_ADDR_W-1:0] CLR_ADDR   = {`CT_IRQ_CLR_IDX, 2'b00};

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tick_if tk ();

  bus_state_t                state_q;
  bus_state_t                state_d;
  logic                      wr_pend_q;
  logic                      wr_pend_d;
  logic [`CT_ADDR_W-1:0]     addr_q;
  logic [`CT_ADDR_W-1:0]     addr_d;
  logic                      addr_hi_q;
  logic                      addr_hi_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;

  clock_src_t                clk_src_q;
  clock_src_t                clk_src_d;
  clear_mode_t               clr_mode_q;
  clear_mode_t               clr_mode_d;
  logic                      edge_sel_q;
  logic                      edge_sel_d;
  logic                      overflow_irq_enable_q;
  logic                      overflow_irq_enable_d;
  logic                      ovf_lo_q;
  logic                      ovf_lo_d;
  logic                      ovf_hi_q;
  logic                      ovf_hi_d;
  logic                      arm_lo_q;
  logic                      arm_lo_d;
  logic                      arm_hi_q;
  logic                      arm_hi_d;

  logic [`CT_CNT_W-1:0]      cnt_q;
  logic [`CT_CNT_W-1:0]      cnt_d;
  logic [`CT_CNT_W-1:0]      cap_fall_q;
  logic [`CT_CNT_W-1:0]      cap_fall_d;
  logic [`CT_CNT_W-1:0]      cap_rise_q;
  logic [`CT_CNT_W-1:0]      cap_rise_d;
  logic [2:0]                sync_q;
  logic [2:0]                sync_d;

  logic [`CT_IRQ_W-1:0]      irq_stat_q;
  logic [`CT_IRQ_W-1:0]      irq_stat_d;
  logic [`CT_IRQ_W-1:0]      irq_en_q;
  logic [`CT_IRQ_W-1:0]      irq_en_d;
  logic [`CT_IRQ_W-1:0]      irq_set;
  logic [`CT_IRQ_W-1:0]      irq_clr;

  logic                      accept;
  logic                      wr_mode;
  logic                      wr_en;
  logic                      wr_clr;
  logic                      rd_mode;
  logic                      cap_rise;
  logic                      cap_fall;
  logic                      cnt_clear;
  logic                      wrap;
  logic                      clr_lo;
  logic                      clr_hi;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  assign tk.clk_src = clk_src_q;

  capture_prescaler #(
    .DIV_W (`CT_PRESCALE_W)
  ) u_prescaler (
    .clk         (CLOCK),
    .rst         (RST),
    .subclock_in (SUBCLOCK_IN),
    .tk          (tk.src)
  );

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // reads take one wait state so they see writes committed just before
  always_comb begin
    accept    = HSEL & HREADY & HTRANS[1];
    state_d   = state_q;
    wr_pend_d = 1'b0;
    addr_d    = addr_q;
    addr_hi_d = addr_hi_q;
    rdata_d   = rdata_q;
    rd_mode   = 1'b0;
    unique case (state_q)
      BUS_IDLE: begin
        if (accept) begin
          addr_d    = HADDR[`CT_ADDR_W-1:0];
          addr_hi_d = |HADDR[31:`CT_ADDR_W];
          wr_pend_d = HWRITE;
          if (!HWRITE) begin
            state_d = BUS_RD_WAIT;
          end
        end
      end
      BUS_RD_WAIT: begin
        state_d = BUS_IDLE;
        rdata_d = '0;
        if (!addr_hi_q) begin
          unique case (addr_q)
            MODE_ADDR: begin
              // write-only bits read as zero
              rdata_d[`CT_OVERFLOW_FLAG_HIGH_BIT] = ovf_hi_q;
              rdata_d[`CT_OVERFLOW_FLAG_LOW_BIT] = ovf_lo_q;
              rd_mode = 1'b1;
            end
            FALL_ADDR:  rdata_d[`CT_CNT_W-1:0] = cap_fall_q;
            RISE_ADDR:  rdata_d[`CT_CNT_W-1:0] = cap_rise_q;
            COUNT_ADDR: rdata_d[`CT_CNT_W-1:0] = cnt_q;
            STAT_ADDR:  rdata_d[`CT_IRQ_W-1:0] = irq_stat_q;
            EN_ADDR:    rdata_d[`CT_IRQ_W-1:0] = irq_en_q;
            default:    rdata_d = '0;
          endcase
        end
      end
    endcase
  end

  always_comb begin
    wr_mode = wr_pend_q & ~addr_hi_q & (addr_q == MODE_ADDR);
    wr_en   = wr_pend_q & ~addr_hi_q & (addr_q == EN_ADDR);
    wr_clr  = wr_pend_q & ~addr_hi_q & (addr_q == CLR_ADDR);
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q   <= BUS_IDLE;
      wr_pend_q <= 1'b0;
      addr_q    <= '0;
      addr_hi_q <= 1'b0;
      rdata_q   <= '0;
    end else begin
      state_q   <= state_d;
      wr_pend_q <= wr_pend_d;
      addr_q    <= addr_d;
      addr_hi_q <= addr_hi_d;
      rdata_q   <= rdata_d;
    end
  end

  assign HRDATA    = rdata_q;
  assign HREADYOUT = (state_q != BUS_RD_WAIT);
  assign HRESP     = 1'b0;

  // ----------------------------------------------------------------
  // capture input and edges
  // ----------------------------------------------------------------
  // a pin already high at reset release shows as one rising edge
  always_comb begin
    sync_d   = {sync_q[1:0], CAPTURE_IN};
    cap_rise = sync_q[1] & ~sync_q[2];
    cap_fall = ~sync_q[1] & sync_q[2];
    unique case (clr_mode_q)
      CLR_NONE: cnt_clear = 1'b0;
      CLR_FALL: cnt_clear = cap_fall;
      CLR_RISE: cnt_clear = cap_rise;
      CLR_BOTH: cnt_clear = cap_fall | cap_rise;
    endcase
  end

  // ----------------------------------------------------------------
  // counter and captures
  // ----------------------------------------------------------------
  // clear beats a tick in the same cycle, so no wrap is seen then
  always_comb begin
    wrap = tk.tick & ~cnt_clear & (cnt_q == `CT_CNT_MAX);
    cnt_d = cnt_q;
    if (cnt_clear) begin
      cnt_d = `CT_CNT_RESET;
    end else if (tk.tick) begin
      cnt_d = cnt_q + 1'b1;
    end
    cap_fall_d = cap_fall_q;
    cap_rise_d = cap_rise_q;
    // captures take the value before any clear on the same edge
    if (cap_fall) begin
      cap_fall_d = cnt_q;
    end
    if (cap_rise) begin
      cap_rise_d = cnt_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sync_q     <= '0;
      cnt_q      <= `CT_CNT_RESET;
      cap_fall_q <= `CT_CAP_RESET;
      cap_rise_q <= `CT_CAP_RESET;
    end else begin
      sync_q     <= sync_d;
      cnt_q      <= cnt_d;
      cap_fall_q <= cap_fall_d;
      cap_rise_q <= cap_rise_d;
    end
  end

  // ----------------------------------------------------------------
  // mode register and overflow flags
  // ----------------------------------------------------------------
  always_comb begin
    clk_src_d  = clk_src_q;
    clr_mode_d = clr_mode_q;
    edge_sel_d = edge_sel_q;
    overflow_irq_enable_d     = overflow_irq_enable_q;
    if (wr_mode) begin
      clk_src_d  = clock_src_t'(HWDATA[`CT_CKS_LSB +: `CT_SEL_W]);
      clr_mode_d = clear_mode_t'(HWDATA[`CT_CCLR_LSB +: `CT_SEL_W]);
      edge_sel_d = HWDATA[`CT_EDGE_BIT];
      overflow_irq_enable_d     = HWDATA[`CT_OVERFLOW_IRQ_ENABLE_BIT];
    end
    // only a zero written after reading a one clears a flag
    clr_lo = wr_mode & arm_lo_q & ~HWDATA[`CT_OVERFLOW_FLAG_LOW_BIT];
    clr_hi = wr_mode & arm_hi_q & ~HWDATA[`CT_OVERFLOW_FLAG_HIGH_BIT];
    // a wrap in the clearing cycle keeps the flag set
    ovf_lo_d = wrap | (ovf_lo_q & ~clr_lo);
    ovf_hi_d = wrap | (ovf_hi_q & ~clr_hi);
    arm_lo_d = arm_lo_q;
    arm_hi_d = arm_hi_q;
    if (wr_mode) begin
      arm_lo_d = 1'b0;
      arm_hi_d = 1'b0;
    end
    if (rd_mode) begin
      arm_lo_d = ovf_lo_q;
      arm_hi_d = ovf_hi_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      clk_src_q  <= CLK_DIV64;
      clr_mode_q <= CLR_NONE;
      edge_sel_q <= 1'b0;
      overflow_irq_enable_q     <= 1'b0;
      ovf_lo_q   <= 1'b0;
      ovf_hi_q   <= 1'b0;
      arm_lo_q   <= 1'b0;
      arm_hi_q   <= 1'b0;
    end else begin
      clk_src_q  <= clk_src_d;
      clr_mode_q <= clr_mode_d;
      edge_sel_q <= edge_sel_d;
      overflow_irq_enable_q     <= overflow_irq_enable_d;
      ovf_lo_q   <= ovf_lo_d;
      ovf_hi_q   <= ovf_hi_d;
      arm_lo_q   <= arm_lo_d;
      arm_hi_q   <= arm_hi_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, enable and clear
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[`CT_IRQ_OVF_BIT] = wrap & overflow_irq_enable_q;
    irq_set[`CT_IRQ_CAP_BIT] = edge_sel_q ? cap_fall : cap_rise;
    irq_clr = wr_clr ? HWDATA[`CT_IRQ_W-1:0] : '0;
    irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);
    irq_en_d = wr_en ? HWDATA[`CT_IRQ_W-1:0] : irq_en_q;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_stat_q <= `CT_IRQ_RESET;
      irq_en_q   <= `CT_IRQ_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_en_q   <= irq_en_d;
    end
  end

  assign IRQ = |(irq_stat_q & irq_en_q);
endmodule

// ---- testbench/capture_timer_8bit_props.sv ----
// port-level checker of the capture timer
`timescale 1ns/1ps
`include "capture_timer_params.svh"
module capture_timer_8bit_props (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // bus
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // interrupt
  input wire logic        IRQ
);
  logic [1:0]  ph_q;
  logic [11:0] a_q;
  logic [1:0]  en_q;
  wire         take = HSEL && HREADY && HTRANS[1];
  wire         rd_end = ph_q[1] && HREADY;
  wire         mode_rd = rd_end && a_q == `CT_MODE_IDX * 4;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // shadow of the enable register, so masking can be judged from the ports
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ph_q <= 2'b00;
      en_q <= 2'b00;
    end else if (HREADY) begin
      ph_q <= {take && !HWRITE, take && HWRITE};
      a_q  <= HADDR[11:0];
      if (ph_q[0] && a_q == `CT_IRQ_EN_IDX * 4) en_q <= HWDATA[1:0];
    end
  end
  AST_WRITE_NOWAIT: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  AST_READ_WAIT: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  AST_ONE_WAIT: assert property (!HREADYOUT |=> HREADYOUT)
    else $error("wait longer than one cycle");
  AST_RDATA_HOLD: assert property (
    HREADYOUT && $past(HREADYOUT) && !$past(RST) |-> $stable(HRDATA))
    else $error("read data moved");
  AST_UPPER_ZERO: assert property (rd_end |-> HRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_MODE_WO: assert property (mode_rd |-> HRDATA[5:0] == 6'h0)
    else $error("write-only mode bits read back");
  AST_IRQ_MASKED: assert property (en_q == 2'b00 |-> !IRQ)
    else $error("interrupt while disabled");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    RST |=> !IRQ && HREADYOUT && HRDATA == 32'h0) else $error("outputs busy after reset");
  AST_RESP_OKAY: assert property (!HRESP)
    else $error("error response");
endmodule
bind capture_timer_8bit capture_timer_8bit_props i_props (
  .CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));

// ---- testbench/capture_source.sv ----
// external capture pin and subclock source
`timescale 1ns/1ps
module capture_source (
  // clock
  input wire logic clk,
  // pins towards the timer
  output logic     cap,
  output logic     sub
);
  logic [1:0] div_q;
  initial begin
    cap   = 1'b0;
    sub   = 1'b0;
    div_q = 2'b00;
  end
  // subclock at clk/8: slow enough that every edge survives the synchroniser
  always @(posedge clk) begin
    div_q <= div_q + 2'b01;
    if (div_q == 2'b11) sub <= ~sub;
  end
  // pin changes just after an edge and then holds for a whole number of cycles
  task automatic toggle(input int hold);
    cap <= ~cap;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// ---- testbench/test_capture_timer_8bit.sv ----
// self-checking bench of the 8-bit input-capture timer
`timescale 1ns/1ps
`include "capture_timer_params.svh"
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_capture_timer_8bit;
  import capture_timer_pkg::*;
  logic        clock, rst, hsel, hwrite, irq, hready, hresp, cap, sub;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  int          fails = 0;
  int          check_count = 0;
  always #5 clock = ~clock;
  capture_timer_8bit i_dut (
    .CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .CAPTURE_IN(cap),
    .SUBCLOCK_IN(sub), .IRQ(irq));
  capture_source i_src (.clk(clock), .cap(cap), .sub(sub));
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // value seen right after the edge is the one sampled at it
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0, idx, 2'b00};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic chk_rd(input logic [9:0] idx, input logic [31:0] e, input string nm);
    bus(1'b0, idx, 32'h0);
    `CHECK(nm, e, rd)
  endtask
  task automatic t_reset();
    for (int i = `CT_MODE_IDX; i <= `CT_IRQ_CLR_IDX; i++) begin
      chk_rd(10'(i), 32'h0, "reset value");
    end
    chk_rd(10'h0FC, 32'h0, "unmapped");
    bus(1'b1, `CT_FALL_IDX, 32'hFF);
    bus(1'b1, `CT_RISE_IDX, 32'hFF);
    chk_rd(`CT_FALL_IDX, 32'h0, "fall capture");
    chk_rd(`CT_RISE_IDX, 32'h0, "rise capture");
    bus(1'b1, `CT_MODE_IDX, 32'h3F);
    chk_rd(`CT_MODE_IDX, 32'h0, "mode readback");
  endtask
  // 128 cycles between the two loads; subclock source gives one tick per 32
  task automatic t_count();
    int   div [4] = '{64, 32, 2, 32};
    logic [7:0] c0;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `CT_MODE_IDX, 32'(s));
      bus(1'b0, `CT_COUNT_IDX, 32'h0);
      c0 = rd[7:0];
      repeat (125) @(posedge clock);
      bus(1'b0, `CT_COUNT_IDX, 32'h0);
      `CHECK("count step", 8'(128 / div[s]), rd[7:0] - c0)
    end
  endtask
  // pulse widths of 81 cycles give exactly 40 ticks at /2 after a clear
  task automatic t_capture();
    logic [7:0] f, r;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `CT_MODE_IDX, {27'h0, m[0], m[1:0], CLK_DIV2});
      bus(1'b1, `CT_IRQ_CLR_IDX, 32'h3);
      bus(1'b1, `CT_IRQ_EN_IDX, 32'h2);
      i_src.toggle(81);
      `CHECK("irq after rise", !m[0], irq)
      i_src.toggle(81);
      `CHECK("irq after fall", 1'b1, irq)
      i_src.toggle(10);
      bus(1'b0, `CT_FALL_IDX, 32'h0);
      f = rd[7:0];
      bus(1'b0, `CT_RISE_IDX, 32'h0);
      r = rd[7:0];
      if (m[0]) `CHECK("rise capture", 8'd40, r)
      if (m[1]) `CHECK("fall capture", 8'd40, f)
      if (m == 0) `CHECK("no clear", 1'b1, r - f inside {8'd40, 8'd41})
      i_src.toggle(10);
    end
  endtask
  task automatic t_overflow();
    int n;
    bus(1'b1, `CT_MODE_IDX, 32'h22);
    bus(1'b1, `CT_IRQ_CLR_IDX, 32'h3);
    bus(1'b1, `CT_IRQ_EN_IDX, 32'h1);
    for (n = 0; irq !== 1'b1 && n < 600; n++) @(posedge clock);
    if (n == 600) begin
      fails++;
      close_out();
    end
    chk_rd(`CT_IRQ_STAT_IDX, 32'h1, "overflow status");
    bus(1'b1, `CT_MODE_IDX, 32'h22);
    chk_rd(`CT_MODE_IDX, 32'hC0, "flags unread");
    bus(1'b1, `CT_MODE_IDX, 32'hA2);
    chk_rd(`CT_MODE_IDX, 32'h80, "low flag cleared");
    bus(1'b1, `CT_MODE_IDX, 32'h22);
    chk_rd(`CT_MODE_IDX, 32'h0, "high flag cleared");
    bus(1'b1, `CT_IRQ_EN_IDX, 32'h0);
    @(posedge clock);
    `CHECK("irq masked", 1'b0, irq)
    bus(1'b1, `CT_IRQ_EN_IDX, 32'h1);
    @(posedge clock);
    `CHECK("irq unmasked", 1'b1, irq)
    bus(1'b1, `CT_IRQ_CLR_IDX, 32'h1);
    chk_rd(`CT_IRQ_STAT_IDX, 32'h0, "status cleared");
    `CHECK("irq cleared", 1'b0, irq)
    bus(1'b1, `CT_MODE_IDX, 32'h02);
    bus(1'b1, `CT_IRQ_CLR_IDX, 32'h3);
    repeat (600) @(posedge clock);
    chk_rd(`CT_IRQ_STAT_IDX, 32'h0, "no overflow request");
    chk_rd(`CT_MODE_IDX, 32'hC0, "flags still set");
  endtask
  initial begin
    clock  = 1'b0;
    rst    = 1'b1;
    hsel   = 1'b0;
    htrans = 2'b00;
    haddr  = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_count();
    t_capture();
    t_overflow();
    close_out();
  end
endmodule
